// ### src/srd_pkg.sv
`default_nettype none
package srd_pkg;
  // ==========================================================
  // Command byte layout
  localparam int SRD_CMD_W = 8;
  localparam int SRD_EN_BIT = 7;
  localparam int SRD_DIR_BIT = 6;
  localparam int SRD_CODE_W = 6;
  localparam int SRD_MAX_W = 24;
  localparam logic [7:0] SRD_CMD_RST = 8'h00;
  localparam logic [7:0] SRD_STATUS_RST = 8'h80;
  localparam logic [4:0] SRD_CNT_W8 = 5'h07;
  // ==========================================================
  // Target codes
  localparam logic [5:0] SRD_C_STATUS = 6'h00;
  localparam logic [5:0] SRD_C_ADCMODE = 6'h01;
  localparam logic [5:0] SRD_C_IFMODE = 6'h02;
  localparam logic [5:0] SRD_C_CHECKSUM = 6'h03;
  localparam logic [5:0] SRD_C_DATA = 6'h04;
  localparam logic [5:0] SRD_C_GPIO = 6'h06;
  localparam logic [5:0] SRD_C_IDENT = 6'h07;
  localparam logic [3:0] SRD_G_CHANNEL = 4'h4;
  localparam logic [3:0] SRD_G_SETUP = 4'h8;
  localparam logic [3:0] SRD_G_FILTER = 4'hA;
  localparam logic [3:0] SRD_G_OFFSET = 4'hC;
  localparam logic [3:0] SRD_G_GAIN = 4'hE;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SRD_ST_CMD = 2'b00,
    SRD_ST_WR = 2'b01,
    SRD_ST_RD = 2'b11
  } srd_state_e;
  typedef enum logic [3:0] {
    SRD_K_NONE, SRD_K_STATUS, SRD_K_ADCMODE, SRD_K_IFMODE,
    SRD_K_CHECKSUM, SRD_K_DATA, SRD_K_GPIO, SRD_K_IDENT,
    SRD_K_CHANNEL, SRD_K_SETUP, SRD_K_FILTER, SRD_K_OFFSET,
    SRD_K_GAIN
  } srd_kind_e;
  typedef struct packed {
    logic valid;
    srd_kind_e kind;
    logic [1:0] idx;
    logic [4:0] last_bit;
  } srd_target_s;
endpackage
`default_nettype wire

// ### src/srd_target_map.sv
`default_nettype none
module srd_target_map
  import srd_pkg::*;
(
  input wire logic [SRD_CODE_W-1:0] code,
  output srd_target_s tgt
);
  always_comb
  begin
    tgt.valid = 1'b1;
    tgt.kind = SRD_K_NONE;
    tgt.idx = code[1:0];
    tgt.last_bit = 5'h0F;
    if (code == SRD_C_STATUS)
    begin
      tgt.kind = SRD_K_STATUS;
      tgt.last_bit = SRD_CNT_W8;
    end
    else if (code == SRD_C_ADCMODE)
      tgt.kind = SRD_K_ADCMODE;
    else if (code == SRD_C_IFMODE)
      tgt.kind = SRD_K_IFMODE;
    else if (code == SRD_C_CHECKSUM)
    begin
      tgt.kind = SRD_K_CHECKSUM;
      tgt.last_bit = 5'h17;
    end
    else if (code == SRD_C_DATA)
    begin
      tgt.kind = SRD_K_DATA;
      tgt.last_bit = 5'h17;
    end
    else if (code == SRD_C_GPIO)
      tgt.kind = SRD_K_GPIO;
    else if (code == SRD_C_IDENT)
      tgt.kind = SRD_K_IDENT;
    else if (code[5:2] == SRD_G_CHANNEL)
      tgt.kind = SRD_K_CHANNEL;
    else if (code[5:2] == SRD_G_SETUP)
      tgt.kind = SRD_K_SETUP;
    else if (code[5:2] == SRD_G_FILTER)
      tgt.kind = SRD_K_FILTER;
    else if (code[5:2] == SRD_G_OFFSET)
    begin
      tgt.kind = SRD_K_OFFSET;
      tgt.last_bit = 5'h17;
    end
    else if (code[5:2] == SRD_G_GAIN)
    begin
      tgt.kind = SRD_K_GAIN;
      tgt.last_bit = 5'h17;
    end
    else
    begin
      tgt.valid = 1'b0;
      tgt.idx = 2'b00;
      tgt.last_bit = SRD_CNT_W8;
    end
  end
endmodule
`default_nettype wire

// ### src/srd_cmd_decoder.sv
// What this block does
// - The command byte picks the target and direction of the next transfer.
// - A byte is taken as a command only when its bit 7 is low.
// - Bit 6 low means a register write follows, high means a read.
// - The low six bits of the byte are the target register code.
// - Codes 0-4, 6 and 7 select status to identification registers.
// - Codes 0x10-0x13, 0x30-0x33, 0x38-0x3B select channel, offset, gain.
// - Codes 0x20-0x23 select setup configuration registers 0 to 3.
// - Codes 0x28-0x2B select filter configuration registers 0 to 3.
// - The command register resets to zero and is write-only.
// - A read of code 0 returns the 8-bit status, reset value 0x80.
`default_nettype none
module srd_cmd_decoder
  import srd_pkg::*;
#(
  parameter int CMD_W = SRD_CMD_W,
  parameter int DATA_W = SRD_MAX_W
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic [7:0] status_in,
  input wire logic [DATA_W-1:0] rd_data,
  output logic [SRD_CODE_W-1:0] rd_code,
  output logic rd_req,
  output logic wr_stb,
  output logic [SRD_CODE_W-1:0] wr_code,
  output logic [DATA_W-1:0] wr_data
);
  // ==========================================================
  // Elaboration checks
  if (CMD_W != SRD_CMD_W || DATA_W != SRD_MAX_W)
  begin : g_bad_width
    $error("srd_cmd_decoder: unsupported width parameter");
  end

  // ==========================================================
  // Declarations
  srd_state_e state_q;
  logic [CMD_W-1:0] cmd_q;
  logic [CMD_W-1:0] shift_in_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rshift_q;
  logic [4:0] cnt_q;
  logic loaded_q;
  logic sclk_q;
  logic [7:0] status_q;
  logic dout_q;
  logic dout_oe_q;
  logic [SRD_CODE_W-1:0] rd_code_q;
  logic rd_req_q;
  logic wr_stb_q;
  logic [SRD_CODE_W-1:0] wr_code_q;
  logic [DATA_W-1:0] wr_data_q;
  logic rise;
  logic fall;
  logic [CMD_W-1:0] byte_in;
  logic [DATA_W-1:0] src;
  logic [DATA_W-1:0] src_aligned;
  srd_target_s tgt;

  // Pins are synchronous to core_clk, so the edge is seen directly
  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;
  assign byte_in = {shift_in_q[CMD_W-2:0], din};

  // decode of the stored target code
  srd_target_map u_map (
    .code(cmd_q[SRD_CODE_W-1:0]),
    .tgt(tgt)
  );

  // ==========================================================
  // Clock edge tracking
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      sclk_q <= 1'b1;
    else
      sclk_q <= sclk;
  end

  // ==========================================================
  // Status register
  // status reset and capture
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      status_q <= SRD_STATUS_RST;
    else
      status_q <= status_in;
  end

  // ==========================================================
  // Transaction sequencer
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= SRD_ST_CMD;
      cmd_q <= SRD_CMD_RST;
      shift_in_q <= SRD_CMD_RST;
      wdata_q <= '0;
      cnt_q <= 5'h00;
    end
    else if (cs_n)
    begin
      // Deselect aborts a half-done transfer; nothing is committed
      state_q <= SRD_ST_CMD;
      cnt_q <= 5'h00;
    end
    else if (rise)
    begin
      case (state_q)
        SRD_ST_CMD:
        begin
          shift_in_q <= byte_in;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == SRD_CNT_W8)
          begin
            cnt_q <= 5'h00;
            // accept only with bit 7 low
            if (!byte_in[SRD_EN_BIT])
            begin
              cmd_q <= byte_in;
              // Short writes must not carry bits of an earlier transfer
              wdata_q <= '0;
              state_q <= byte_in[SRD_DIR_BIT] ? SRD_ST_RD : SRD_ST_WR;
            end
          end
        end
        SRD_ST_WR:
        begin
          wdata_q <= {wdata_q[DATA_W-2:0], din};
          cnt_q <= cnt_q + 5'h01;
          // back to command wait after full width
          if (cnt_q == tgt.last_bit)
          begin
            cnt_q <= 5'h00;
            state_q <= SRD_ST_CMD;
          end
        end
        SRD_ST_RD:
        begin
          cnt_q <= cnt_q + 5'h01;
          // back to command wait after full width
          if (cnt_q == tgt.last_bit)
          begin
            cnt_q <= 5'h00;
            state_q <= SRD_ST_CMD;
          end
        end
        default:
        begin
          state_q <= SRD_ST_CMD;
          cnt_q <= 5'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // Write commit
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_stb_q <= 1'b0;
      wr_code_q <= '0;
      wr_data_q <= '0;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      if (!cs_n && rise && state_q == SRD_ST_WR &&
          cnt_q == tgt.last_bit)
      begin
        // unmapped and read-only status writes are dropped
        wr_stb_q <= tgt.valid && (tgt.kind != SRD_K_STATUS);
        // Dropped writes leave the last committed code and data alone
        if (tgt.valid && (tgt.kind != SRD_K_STATUS))
        begin
          wr_code_q <= cmd_q[SRD_CODE_W-1:0];
          wr_data_q <= {wdata_q[DATA_W-2:0], din};
        end
      end
    end
  end

  // ==========================================================
  // Read request toward the register file
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_req_q <= 1'b0;
      rd_code_q <= '0;
    end
    else
    begin
      rd_req_q <= 1'b0;
      if (!cs_n && rise && state_q == SRD_ST_CMD &&
          cnt_q == SRD_CNT_W8 && !byte_in[SRD_EN_BIT] &&
          byte_in[SRD_DIR_BIT])
      begin
        rd_req_q <= 1'b1;
        rd_code_q <= byte_in[SRD_CODE_W-1:0];
      end
    end
  end

  // ==========================================================
  // Read data source
  always_comb
  begin
    src = rd_data;
    if (tgt.kind == SRD_K_STATUS)
      src = {16'h0000, status_q};
    else if (!tgt.valid)
      src = '0;
    if (tgt.last_bit == SRD_CNT_W8)
      src_aligned = {src[7:0], 16'h0000};
    else if (tgt.last_bit == 5'h0F)
      src_aligned = {src[15:0], 8'h00};
    else
      src_aligned = src;
  end

  // ==========================================================
  // Read shifter, changes on the falling serial edge
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rshift_q <= '0;
      loaded_q <= 1'b0;
      dout_q <= 1'b0;
    end
    else if (cs_n || state_q != SRD_ST_RD)
      loaded_q <= 1'b0;
    else if (fall)
    begin
      loaded_q <= 1'b1;
      if (!loaded_q)
      begin
        // Sampled here, a full half bit after the request pulse
        rshift_q <= {src_aligned[DATA_W-2:0], 1'b0};
        dout_q <= src_aligned[DATA_W-1];
      end
      else
      begin
        rshift_q <= {rshift_q[DATA_W-2:0], 1'b0};
        dout_q <= rshift_q[DATA_W-1];
      end
    end
  end

  // ==========================================================
  // Output enable
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      dout_oe_q <= 1'b0;
    else
      dout_oe_q <= ~cs_n;
  end

  assign dout = dout_q;
  assign dout_oe = dout_oe_q;
  assign rd_code = rd_code_q;
  assign rd_req = rd_req_q;
  assign wr_stb = wr_stb_q;
  assign wr_code = wr_code_q;
  assign wr_data = wr_data_q;
endmodule
`default_nettype wire

// ### sim/srd_assertions.sv
`default_nettype none
module srd_assertions
  import srd_pkg::*;
#(
  parameter int DATA_W = SRD_MAX_W
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_oe,
  input wire logic rd_req,
  input wire logic wr_stb,
  input wire logic [SRD_CODE_W-1:0] rd_code,
  input wire logic [SRD_CODE_W-1:0] wr_code,
  input wire logic [DATA_W-1:0] wr_data
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Link checks
  oe_on_select_a:
    assert property ($fell(cs_n) |=> dout_oe)
    else $error("output enable missing after select");
  stb_single_a:
    assert property (wr_stb |=> !wr_stb)
    else $error("write strobe longer than one cycle");
  req_single_a:
    assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  stb_on_rise_a:
    assert property (wr_stb |-> $past(sclk) && !$past(sclk, 2)
      && !$past(cs_n))
    else $error("write strobe not after a clock rise");
  req_on_rise_a:
    assert property (rd_req |-> $past(sclk) && !$past(sclk, 2)
      && !$past(cs_n))
    else $error("read request not after a clock rise");
  idle_no_commit_a:
    assert property (cs_n |=> !wr_stb && !rd_req)
    else $error("commit while deselected");
  wr_mapped_a:
    assert property (wr_stb |-> wr_code inside {[1:4], 6, 7,
      [16:19], [32:35], [40:43], [48:51], [56:59]})
    else $error("write strobe for unmapped code");
  rd_code_hold_a:
    assert property (!rd_req |-> $stable(rd_code))
    else $error("read code moved without request");
  wr_hold_a:
    assert property (!wr_stb |-> $stable(wr_data) && $stable(wr_code))
    else $error("write outputs moved without strobe");
endmodule
bind srd_cmd_decoder srd_assertions #(.DATA_W(DATA_W)) chk_u (
  .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
  .dout_oe(dout_oe), .rd_req(rd_req), .wr_stb(wr_stb),
  .rd_code(rd_code), .wr_code(wr_code), .wr_data(wr_data)
);
`default_nettype wire

// ### sim/srd_host_model.sv
`default_nettype none
module srd_host_model (
  input wire logic core_clk,
  input wire logic dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // ==========================================================
  // frame select
  task automatic sel(input logic on);
    @(negedge core_clk);
    cs_n = ~on;
    // Released data line must not keep its last bit
    if (!on)
      din = ~din;
  endtask
  task automatic shift(input int n, input logic [23:0] v,
    output logic [23:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(negedge core_clk);
      sclk = 1'b0;
      din = v[i];
      // Two low cycles give the registered output time to settle
      @(negedge core_clk);
      @(negedge core_clk);
      r[i] = dout;
      sclk = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ### sim/serial_register_command_decoder_tb_top.sv
`default_nettype none
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("unexpected at %0t: %h not %h", $time, g, e); \
    end \
  end
module serial_register_command_decoder_tb_top
  import srd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n, sclk, din, dout, dout_oe, rd_req, wr_stb;
  logic [7:0] status_in = 8'h5A;
  logic [5:0] rd_code, wr_code;
  logic [23:0] rd_data, wr_data, got;
  int n_fail = 0;
  int n_tests = 0;
  int n_stb = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  // Far-side register file answers a pattern built from the code
  assign rd_data = {4{rd_code}};
  srd_host_model host_u (.core_clk(core_clk), .dout(dout),
    .cs_n(cs_n), .sclk(sclk), .din(din));
  srd_cmd_decoder dut_u (.core_clk(core_clk), .rstn(rstn),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .status_in(status_in), .rd_data(rd_data),
    .rd_code(rd_code), .rd_req(rd_req), .wr_stb(wr_stb),
    .wr_code(wr_code), .wr_data(wr_data));
  function automatic int wid(logic [5:0] c);
    if (c inside {3, 4, [48:51], [56:59]})
      return 24;
    if (c inside {1, 2, 6, 7, [16:19], [32:35], [40:43]})
      return 16;
    return 8;
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic txn(input logic [7:0] cmd, input int w,
    input logic [23:0] v);
    host_u.shift(8, {16'h0, cmd}, got);
    host_u.shift(w, v, got);
    repeat (3) @(negedge core_clk);
  endtask
  always @(negedge core_clk)
  begin
    cyc++;
    if (wr_stb === 1'b1)
      n_stb++;
    if (cyc == 30000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // ==========================================================
  // Tests
  initial
  begin
    logic [5:0] k;
    logic [23:0] m;
    int s;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    host_u.sel(1'b1);
    for (int c = 0; c < 64; c++)
    begin
      k = c[5:0];
      m = ~(24'hFFFFFF << wid(k));
      s = n_stb;
      txn({2'b00, k}, wid(k), 24'hC35A96);
      `CHK(n_stb - s, int'(wid(k) > 8))
      if (wid(k) > 8)
      begin
        `CHK(wr_code, k)
        `CHK(wr_data, 24'hC35A96 & m)
      end
      txn({2'b01, k}, wid(k), 24'h0);
      `CHK(rd_code, k)
      `CHK(got, (k == 0) ? {16'h0, status_in} :
        (wid(k) > 8) ? ({4{k}} & m) : 24'h0)
    end
    host_u.sel(1'b0);
    $display("test code map done");
    s = n_stb;
    host_u.sel(1'b1);
    host_u.shift(8, 24'hC1, got);
    txn(8'h02, 16, 24'h00BEEF);
    `CHK(n_stb - s, 1)
    `CHK(wr_code, 6'h02)
    `CHK(wr_data, 24'h00BEEF)
    host_u.shift(8, 24'h01, got);
    host_u.shift(8, 24'hFF, got);
    host_u.sel(1'b0);
    repeat (3) @(negedge core_clk);
    `CHK(n_stb - s, 1)
    `CHK(dout_oe, 1'b0)
    host_u.sel(1'b1);
    txn(8'h41, 16, 24'h0);
    host_u.sel(1'b0);
    `CHK(got, 24'h001041)
    host_u.sel(1'b1);
    status_in = 8'hC3;
    txn(8'h40, 8, 24'h0);
    host_u.sel(1'b0);
    `CHK(got, 24'h0000C3)
    `CHK(rd_code, 6'h00)
    $display("test refuse and abort done");
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
